// file: hdl/burst_memory_read_sequencer.sv
// Read-path sequencer for synchronous burst SRAM and page-mode DRAM.
// Assumes a processor on the same clock and a buffer drain on rd_*.
`timescale 1ns/1ps
`default_nettype none
module burst_memory_read_sequencer #(
    parameter int DW    = bmrs_pkg::DATA_W,     // Data width
    parameter int DEPTH = bmrs_pkg::FIFO_DEPTH  // Return buffer depth
) (
    input  wire logic          ref_clk,     // Memory-bus clock
    input  wire logic          rst_n,       // Synchronous reset, low
    input  wire logic          cpu_mreq_n,  // Memory request, low
    input  wire logic          cpu_clf,     // Cache line fill flag
    input  wire logic [1:0]    cpu_word,    // Low word address bits
    input  wire logic          cpu_dram,    // Access decodes to DRAM
    output logic               cpu_wait_n,  // Wait, low stalls processor
    input  wire logic [DW-1:0] mem_rdata,   // Read data from memory
    output logic               sram_adsc_n, // SRAM address load, low
    output logic               sram_adv_n,  // SRAM burst advance, low
    output logic               sram_oe_n,   // SRAM output enable, low
    output logic               ras_n,       // DRAM row strobe, low
    output logic [3:0]         cas_n,       // DRAM column strobes, low
    output logic               sel_col,     // DRAM column select
    output logic               rd_valid,    // Buffered beat valid
    input  wire logic          rd_ready,    // Buffered beat taken
    output logic [DW-1:0]      rd_data,     // Buffered beat
    output logic [bmrs_pkg::BCNT_W-1:0] bcnt // Burst counter state
);
    import bmrs_pkg::*;

    bmrs_main_state_type st_q;     // Main state
    logic [BCNT_W-1:0]   bcnt_q;   // Beats left in block after this one
    logic                buf_rdy;  // Return buffer has room
    logic                start;    // New request seen in idle
    logic                sbeat;    // SRAM beat delivered this cycle
    logic                dbeat;    // DRAM beat delivered this cycle
    logic                more;     // Processor wants further beats

    bmrs_dram_if dif ();  // Link to the DRAM sequencer

    // Output-enable phase of the SRAM path; shared by pin and checks
    function automatic logic sram_out_phase(input bmrs_main_state_type s);
        return (s == st_read_second) || (s == st_read_third);
    endfunction : sram_out_phase

    // Stall states of the SRAM path; wait must stay low in all of them
    function automatic logic sram_stall_phase(input bmrs_main_state_type s);
        return (s == st_read_first) || (s == st_read_reload) || (s == st_read_third);
    endfunction : sram_stall_phase

    // Request decode; the processor keeps request low while beats remain after the current one
    assign start = (st_q == st_idle) && !cpu_mreq_n;
    assign more  = !cpu_mreq_n;

    // A beat only completes when the buffer can hold it
    assign sbeat = (st_q == st_read_second) && buf_rdy;
    assign dbeat = (st_q == st_dram) && dif.dram_ack && buf_rdy;

    // Wait is released only on data cycles; stalls keep it low
    assign cpu_wait_n = sbeat || dbeat;

    // Address load at first access and at each block boundary
    assign sram_adsc_n = !((start && !cpu_dram) || (st_q == st_read_reload));
    assign sram_adv_n  = !sbeat;  // Internal burst advance per beat
    assign sram_oe_n   = !sram_out_phase(st_q);

    // DRAM request held for as long as the processor requests
    assign dif.do_dram = ((st_q == st_idle) && start && cpu_dram)
                       || ((st_q == st_dram) && !(dif.dram_ack && !more));
    assign dif.take    = buf_rdy;
    assign bcnt        = bcnt_q;

    // Cycle walk of an SRAM read; cycle 0 is the request cycle:
    //   c0  idle, request seen, address load strobed
    //   c1  first state, one latency stall, wait low
    //   c2  second state, first beat, wait high
    //   cN  later beats back to back, counter running down
    // A beat with the counter at zero and the request still low
    // leaves the block:
    //   reload state, new address load, wait low
    //   third state, SRAM latency, wait low
    //   second state again, beats resume, counter at three
    // A beat with the request high is the last; idle follows.
    // Cycle walk of a DRAM read:
    //   c0  idle, request seen, DRAM request raised
    //   c1  row strobe falls
    //   c2  column select
    //   c3  all column strobes for one cycle
    //   c4  acknowledge, wait high if the buffer has room
    //   Later beats loop column, strobe, acknowledge.
    // Limitation: all DRAM beats must share one page, since
    // the row strobe stays low for the whole access.
    // Trade-off: a full buffer stretches the current beat
    // rather than dropping data, so the processor sees
    // extra stalls only when the drain side falls behind.

    // Main state machine
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= st_idle;
        end else begin
            case (st_q)
                st_idle: begin
                    // Decode target on a fresh request
                    if (start) st_q <= cpu_dram ? st_dram : st_read_first;
                end
                st_read_first: begin
                    // Single latency stall after the first load
                    st_q <= st_read_second;
                end
                st_read_second: begin
                    if (sbeat) begin
                        if (!more) begin
                            st_q <= st_idle;
                        end else if (bcnt_q == BCNT_LAST) begin
                            st_q <= st_read_reload;
                        end
                    end
                end
                st_read_reload: begin
                    // First stall: lets the new address settle
                    st_q <= st_read_third;
                end
                st_read_third: begin
                    // Second stall: SRAM access latency
                    st_q <= st_read_second;
                end
                st_dram: begin
                    if (dbeat && !more) st_q <= st_idle;
                end
                default: st_q <= st_idle;
            endcase
        end
    end

    // Burst counter: load, decrement per beat, wrap at boundary
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bcnt_q <= BCNT_RST;
        end else if (start && !cpu_dram) begin
            // Fill wraps in hardware blocks, so start at a full block
            bcnt_q <= cpu_clf ? BCNT_FILL : ~cpu_word;
        end else if (sbeat && more) begin
            bcnt_q <= (bcnt_q == BCNT_LAST) ? BCNT_WRAP : bcnt_q - 1'b1;
        end
    end

    // Return buffer; back-pressure stalls beats via buf_rdy
    bmrs_fifo #(.W(DW), .D(DEPTH)) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (sbeat || dbeat),
        .in_ready  (buf_rdy),
        .in_data   (mem_rdata),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    // DRAM row/column sequencer
    bmrs_dram_seq u_dram (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .hs      (dif),
        .ras_n   (ras_n),
        .cas_n   (cas_n),
        .sel_col (sel_col)
    );

    // Block reload: two stall cycles then data
    sequence seq_reload_stalls;
        (st_q == st_read_reload && !cpu_wait_n) ##1 (st_q == st_read_third && !cpu_wait_n);
    endsequence
    sequence seq_first_stall;
        (st_q == st_read_first && !cpu_wait_n) ##1 (st_q == st_read_second);
    endsequence

    AST_LOAD_COMPL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && !cpu_dram && !cpu_clf) |=> (bcnt_q == ~$past(cpu_word)))
        else $error("counter not loaded with complement of word address");
    AST_LOAD_FILL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && !cpu_dram && cpu_clf) |=> (bcnt_q == BCNT_FILL))
        else $error("line fill did not load counter with three");
    AST_FIRST_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && !cpu_dram) |=> seq_first_stall)
        else $error("first load not followed by exactly one stall");
    AST_NO_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sbeat && more && bcnt_q != BCNT_LAST) |=> (st_q == st_read_second))
        else $error("stall inserted inside a block");
    AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sbeat && more && bcnt_q == BCNT_LAST)
        |=> (bcnt_q == BCNT_WRAP && !sram_adsc_n))
        else $error("block boundary did not wrap and reload");
    AST_TWO_STALLS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_read_reload) |-> seq_reload_stalls ##1 (st_q == st_read_second))
        else $error("block reload stall count wrong");
    AST_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((sbeat || dbeat) && !more) |=> (st_q == st_idle))
        else $error("did not return idle after last beat");
    AST_DRAM_REQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && cpu_dram) |-> dif.do_dram ##1 (st_q == st_dram && dif.do_dram))
        else $error("DRAM request not raised on DRAM decode");
    AST_WAIT_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        dbeat |=> !cpu_wait_n)
        else $error("wait released longer than one cycle on DRAM beat");
    AST_DRAM_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_dram && more) |-> dif.do_dram)
        else $error("DRAM request dropped while processor requests");

    // Further SRAM-path checks: strobes, stalls, counter
    // A load strobe lasts one cycle only
    AST_ADSC_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !sram_adsc_n |=> sram_adsc_n)
        else $error("address load held for two cycles");

    // Every SRAM access opens with an address load
    AST_LOAD_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (start && !cpu_dram) |-> !sram_adsc_n)
        else $error("no address load at start of SRAM read");

    // Reload state always strobes a fresh address
    AST_LOAD_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_read_reload) |-> !sram_adsc_n)
        else $error("no address load at block boundary");

    // DRAM accesses never touch the SRAM address
    AST_NO_LOAD_DRAM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_dram || (start && cpu_dram)) |-> sram_adsc_n)
        else $error("SRAM address load during DRAM access");

    // Stall states keep the processor waiting
    AST_STALL_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sram_stall_phase(st_q) |-> !cpu_wait_n)
        else $error("wait released in a stall state");

    // A full buffer turns a data cycle into a stall
    AST_FULL_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_read_second && !buf_rdy) |-> !cpu_wait_n)
        else $error("wait released while buffer full");

    // Data cycle releases wait and advances the burst
    AST_BEAT_WAIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_read_second && buf_rdy) |-> (cpu_wait_n && !sram_adv_n))
        else $error("data cycle without wait release or advance");

    // SRAM drives data on every beat
    AST_OE_BEAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sbeat |-> (sram_out_phase(st_q) && !sram_oe_n))
        else $error("SRAM output disabled on a beat");

    // Counter steps down by one inside a block
    AST_CNT_DEC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sbeat && more && bcnt_q != BCNT_LAST) |=> (bcnt_q == $past(bcnt_q) - 2'h1))
        else $error("counter did not decrement by one");

    // Counter rests through stall states
    AST_CNT_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sram_stall_phase(st_q) |=> $stable(bcnt_q))
        else $error("counter moved during a stall");

    // Counter rests after the final beat
    AST_CNT_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sbeat && !more) |=> $stable(bcnt_q))
        else $error("counter moved after final beat");

    // Idle without request leaves memory quiet
    AST_IDLE_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_idle && cpu_mreq_n) |-> (sram_adsc_n && !cpu_wait_n && sram_oe_n))
        else $error("memory strobes active while idle");

    // SRAM stays off the bus during DRAM access
    AST_DRAM_NO_SRAM: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_dram) |-> (sram_oe_n && sram_adv_n))
        else $error("SRAM enabled during DRAM access");

    // DRAM-path checks: row, column, strobes, acknowledge
    // One DRAM beat: column select, one strobe cycle, acknowledge
    sequence seq_dram_beat;
        (sel_col && !ras_n) ##1 (cas_n == CAS_ALL_ON) ##1 dif.dram_ack;
    endsequence

    // Row strobe first, column select only afterwards
    AST_ROW_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(ras_n) |-> (!sel_col ##1 seq_dram_beat))
        else $error("row and column order wrong");

    // A continued access loops through another column cycle
    AST_LOOP_BEAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dif.dram_ack && dif.take && dif.do_dram) |=> seq_dram_beat)
        else $error("continued DRAM access did not loop");

    // Byte strobes move together on reads
    AST_CAS_ALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cas_n != CAS_ALL_OFF) |-> (cas_n == CAS_ALL_ON))
        else $error("column strobes not all asserted");

    // Column strobes only under row strobe and column select
    AST_CAS_UNDER_RAS: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cas_n == CAS_ALL_ON) |-> (!ras_n && sel_col))
        else $error("column strobe outside row and column phase");

    // Acknowledge stands until the buffer can take the beat
    AST_ACK_HELD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dif.dram_ack && !buf_rdy) |=> dif.dram_ack)
        else $error("acknowledge lost while buffer full");

    // No wait release between DRAM acknowledges
    AST_DRAM_STALL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == st_dram && !dif.dram_ack) |-> !cpu_wait_n)
        else $error("wait released without DRAM acknowledge");

    // Last beat lifts the row strobe for precharge
    AST_PRECHARGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dif.dram_ack && dif.take && !dif.do_dram) |=> (ras_n ##1 ras_n))
        else $error("row strobe not lifted after last beat");

    // Final beat withdraws the DRAM request
    AST_DRAM_END_REQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (dbeat && !more) |-> !dif.do_dram)
        else $error("DRAM request held after final beat");
endmodule : burst_memory_read_sequencer
`default_nettype wire

// file: hdl/bmrs_pkg.sv
// Shared constants and state types for the burst memory read sequencer.
// Assumes one memory-bus clock and a synchronous active-low reset.
package bmrs_pkg;
    localparam int          DATA_W      = 32;    // Memory data width
    localparam int          FIFO_DEPTH  = 16;    // Read-return buffer depth
    localparam int          BCNT_W      = 2;     // Burst counter width
    localparam logic [1:0]  BCNT_FILL   = 2'h3;  // Cache line fill load value
    localparam logic [1:0]  BCNT_WRAP   = 2'h3;  // Value after block wrap
    localparam logic [1:0]  BCNT_LAST   = 2'h0;  // Last beat of a block
    localparam logic [1:0]  BCNT_RST    = 2'h0;  // Counter after reset
    localparam logic [3:0]  CAS_ALL_ON  = 4'h0;  // All byte strobes asserted
    localparam logic [3:0]  CAS_ALL_OFF = 4'hF;  // All byte strobes idle

    typedef enum logic [2:0] {
        st_idle, st_read_first, st_read_reload, st_read_second, st_read_third, st_dram
    } bmrs_main_state_type;

    typedef enum logic [2:0] {
        ds_idle, ds_row, ds_col, ds_cas, ds_ack, ds_pre
    } bmrs_dram_state_type;
endpackage : bmrs_pkg

// file: hdl/bmrs_dram_if.sv
// Handshake between the main sequencer and the DRAM sequencer.
// Both ends sit on the same clock; no crossing is needed.
`timescale 1ns/1ps
`default_nettype none
interface bmrs_dram_if;
    logic do_dram;   // Main asks for DRAM beats
    logic dram_ack;  // Beat data is valid
    logic take;      // Main can accept the beat now
    modport main (output do_dram, output take, input dram_ack);
    modport seq  (input do_dram, input take, output dram_ack);
endinterface : bmrs_dram_if
`default_nettype wire

// file: hdl/bmrs_fifo.sv
// Parameterised valid/ready FIFO for returned read beats.
// Assumes both sides on one clock; width and depth shape the array.
`timescale 1ns/1ps
`default_nettype none
module bmrs_fifo #(
    parameter int W = 32,  // Word width
    parameter int D = 16   // Depth, power of two
) (
    input  wire logic         ref_clk,   // Memory-bus clock
    input  wire logic         rst_n,     // Synchronous reset, low
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Room available
    input  wire logic [W-1:0] in_data,   // Write word
    output logic              out_valid, // Word available
    input  wire logic         out_ready, // Drain request
    output logic [W-1:0]      out_data   // Head word
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];   // Storage
    logic [AW:0]  wr_q;      // Write pointer with lap bit
    logic [AW:0]  rd_q;      // Read pointer with lap bit

    // Full when pointers differ only in the lap bit
    assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[AW-1:0]];

    // Storage writes
    always_ff @(posedge ref_clk) begin
        if (in_valid && in_ready) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (in_valid && in_ready) wr_q <= wr_q + 1'b1;
            if (out_valid && out_ready) rd_q <= rd_q + 1'b1;
        end
    end
endmodule : bmrs_fifo
`default_nettype wire

// file: hdl/bmrs_dram_seq.sv
// DRAM page-mode sequencer for read beats on EDO parts.
// Assumes one page per sequential access; main holds do_dram per beat.
`timescale 1ns/1ps
`default_nettype none
module bmrs_dram_seq (
    input  wire logic  ref_clk,  // Memory-bus clock
    input  wire logic  rst_n,    // Synchronous reset, low
    bmrs_dram_if.seq   hs,       // Handshake from main
    output logic       ras_n,    // Row strobe, low
    output logic [3:0] cas_n,    // Byte column strobes, low
    output logic       sel_col   // Column address select
);
    import bmrs_pkg::*;
    bmrs_dram_state_type st_q;  // Sequencer state

    // Strobes decoded from state register
    assign ras_n       = (st_q == ds_idle) || (st_q == ds_pre);
    assign sel_col     = (st_q == ds_col) || (st_q == ds_cas) || (st_q == ds_ack);
    assign cas_n       = (st_q == ds_cas) ? CAS_ALL_ON : CAS_ALL_OFF;
    assign hs.dram_ack = (st_q == ds_ack);

    // Row, column, single-cycle strobe, ack, then loop or precharge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= ds_idle;
        end else begin
            case (st_q)
                ds_idle: if (hs.do_dram) st_q <= ds_row;
                ds_row:  st_q <= ds_col;
                ds_col:  st_q <= ds_cas;
                ds_cas:  st_q <= ds_ack;
                ds_ack: begin
                    // Held until taken so a full buffer loses nothing
                    if (hs.take) st_q <= hs.do_dram ? ds_col : ds_pre;
                end
                ds_pre:  st_q <= ds_idle;  // Row precharge before new request
                default: st_q <= ds_idle;
            endcase
        end
    end

    AST_CAS_SINGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cas_n == CAS_ALL_ON) |=> (cas_n == CAS_ALL_OFF))
        else $error("column strobe held longer than one cycle");
    AST_RAS_LOOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hs.dram_ack && hs.take && hs.do_dram) |=> (!ras_n ##1 !ras_n))
        else $error("row strobe dropped inside a sequential read");
endmodule : bmrs_dram_seq
`default_nettype wire

// file: tb/bmrs_cpu_model.sv
// Processor model: issues sequential reads on the request bus.
// Assumes the sequencer on the same clock; the bench pulses start.
`timescale 1ns/1ps
`default_nettype none
module bmrs_cpu_model (
    input  wire logic       ref_clk,    // Bus clock
    input  wire logic       rst_n,      // Sync reset, low
    input  wire logic       start,      // Begin one access
    input  wire logic [4:0] n_beats,    // Beats to move
    input  wire logic [1:0] word,       // First word in block
    input  wire logic       clf,        // Line fill access
    input  wire logic       dram,       // DRAM access
    input  wire logic       cpu_wait_n, // Beat strobe
    output logic            cpu_mreq_n, // Request, low
    output logic            cpu_clf,    // Line fill flag
    output logic [1:0]      cpu_word,   // Word bits
    output logic            cpu_dram,   // DRAM decode
    output logic            busy        // Access in flight
);
    logic [4:0] rem_q; // Beats still owed

    // Request drops once only the last beat is owed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cpu_mreq_n <= 1'b1;
            busy       <= 1'b0;
            rem_q      <= 5'h00;
            cpu_clf    <= 1'b0;
            cpu_word   <= 2'h0;
            cpu_dram   <= 1'b0;
        end else if (start) begin
            cpu_mreq_n <= 1'b0;
            busy       <= 1'b1;
            rem_q      <= n_beats;
            cpu_clf    <= clf;
            cpu_word   <= word;
            cpu_dram   <= dram;
        end else if (busy) begin
            rem_q      <= rem_q - {4'h0, cpu_wait_n};
            cpu_mreq_n <= (rem_q - {4'h0, cpu_wait_n}) <= 5'h01;
            busy       <= !(cpu_wait_n && rem_q == 5'h01);
        end else begin
            // Idle lines wander so stale values are never trusted
            cpu_word   <= ~cpu_word;
            cpu_clf    <= ~cpu_clf;
            cpu_dram   <= ~cpu_dram;
        end
    end
endmodule : bmrs_cpu_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the burst memory read sequencer.
// Assumes the processor model beside it; memory data is random.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import bmrs_pkg::*;
    logic              ref_clk, rst_n, start, clf, dram, hold, rd_ready, busy;
    logic              cpu_mreq_n, cpu_clf, cpu_dram, cpu_wait_n, rd_valid;
    logic              sram_adsc_n, sram_adv_n, sram_oe_n, ras_n, sel_col;
    logic [4:0]        n_beats;
    logic [1:0]        word, cpu_word;
    logic [3:0]        cas_n;
    logic [BCNT_W-1:0] bcnt;
    logic [DATA_W-1:0] mem_rdata, rd_data;
    logic [DATA_W-1:0] exp_q[$]; // Words owed to the drain side
    int                fails = 0, checked = 0, cycles = 0;
    int                tab[11][4] = '{'{9,3,0,0}, '{2,3,0,0}, '{4,1,0,0}, '{1,0,0,0},
        '{2,0,0,0}, '{3,2,0,0}, '{8,1,1,0}, '{8,3,1,0}, '{4,2,0,1}, '{1,0,0,1}, '{2,0,0,1}};

    burst_memory_read_sequencer burst_memory_read_sequencer_inst (.ref_clk(ref_clk),
        .rst_n(rst_n), .cpu_mreq_n(cpu_mreq_n), .cpu_clf(cpu_clf), .cpu_word(cpu_word),
        .cpu_dram(cpu_dram), .cpu_wait_n(cpu_wait_n), .mem_rdata(mem_rdata),
        .sram_adsc_n(sram_adsc_n), .sram_adv_n(sram_adv_n), .sram_oe_n(sram_oe_n),
        .ras_n(ras_n), .cas_n(cas_n), .sel_col(sel_col), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .bcnt(bcnt));
    bmrs_cpu_model bmrs_cpu_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
        .n_beats(n_beats), .word(word), .clf(clf), .dram(dram), .cpu_wait_n(cpu_wait_n),
        .cpu_mreq_n(cpu_mreq_n), .cpu_clf(cpu_clf), .cpu_word(cpu_word),
        .cpu_dram(cpu_dram), .busy(busy));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic finish_test;
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    // Memory data and drain stalls change every cycle
    always @(posedge ref_clk) begin
        mem_rdata <= $urandom;
        rd_ready  <= hold ? 1'b0 : 1'($urandom);
    end

    // Hang guard, far above the planned run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end

    // Note every delivered beat, compare when drained
    always @(negedge ref_clk) begin
        if (rst_n && cpu_wait_n === 1'b1)
            exp_q.push_back(mem_rdata);
        if (rst_n && rd_valid === 1'b1 && rd_ready) begin
            chk(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) chk(rd_data, exp_q.pop_front());
        end
    end

    task automatic do_reset(input int k);
        rst_n <= 1'b0;
        repeat (k) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        exp_q.delete();
        chk({cpu_wait_n, sram_adsc_n, ras_n, cas_n, rd_valid, bcnt},
            {1'b0, 1'b1, 1'b1, CAS_ALL_OFF, 1'b0, BCNT_RST});
    endtask : do_reset

    task automatic issue(input int n, input logic [1:0] w, input logic c, input logic d);
        @(posedge ref_clk);
        n_beats <= 5'(n);
        word    <= w;
        clf     <= c;
        dram    <= d;
        start   <= 1'b1;
        @(posedge ref_clk);
        start   <= 1'b0;
    endtask : issue

    // One access; timing expectations from the block-walk arithmetic
    task automatic run(input int n, input logic [1:0] w, input logic c, input logic d);
        int         cyc = 0, beats = 0, last = 0, adsc = 0, casc = 0, rl = 0, stl = 0;
        logic       hm = hold;
        logic [1:0] b0 = c ? BCNT_FILL : ~w;
        logic [1:0] b = b0;
        for (int i = 1; i < n; i++) begin
            if (b == BCNT_LAST) begin
                rl++;
                b = BCNT_WRAP;
            end else
                b--;
        end
        issue(n, w, c, d);
        @(negedge ref_clk);
        while (beats < n && cyc < 400) begin
            if (sram_adsc_n === 1'b0) adsc++;
            if (cas_n === CAS_ALL_ON) casc++;
            if (d && cyc == 2) chk({ras_n, sel_col}, 2'b01);
            if (cpu_wait_n === 1'b1) begin
                beats++;
                last = cyc;
                if (beats == 1 && !d) chk(bcnt, b0);
                if (d) chk(ras_n, 1'b0);
                if (!d) chk({sram_adv_n, sram_oe_n}, 2'b00);
            end
            if (hold && beats == 16) stl++;
            if (stl == 10) hold = 1'b0;
            cyc++;
            @(negedge ref_clk);
        end
        hold = 1'b0;
        chk(beats, n);
        if (hm) chk(stl, 10);
        else chk(last, d ? 4 + 3 * (n - 1) : 1 + n + 2 * rl);
        chk(adsc, d ? 0 : 1 + rl);
        chk(casc, d ? n : 0);
        repeat (4) @(negedge ref_clk);
        chk({ras_n, sram_oe_n, cas_n}, 6'h3F);
        for (int k = 0; k < 200 && rd_valid !== 1'b0; k++) @(negedge ref_clk);
        chk(rd_valid, 1'b0);
        chk(exp_q.size(), 0);
    endtask : run

    initial begin
        void'($urandom(32'h64DC));
        {rst_n, start, clf, dram, hold, rd_ready} = 6'h00;
        n_beats   = 5'h00;
        word      = 2'h0;
        mem_rdata = 32'h0;
        do_reset(8);
        foreach (tab[i]) run(tab[i][0], 2'(tab[i][1]), tab[i][2][0], tab[i][3][0]);
        repeat (8) run(1 + $urandom_range(8), 2'($urandom), 1'b0, 1'($urandom));
        // Buffer fills, beats must stall, then drain
        hold = 1'b1;
        run(20, 2'h0, 1'b0, 1'b0);
        // Reset in mid-burst, then a clean read
        issue(9, 2'h0, 1'b0, 1'b0);
        repeat (4) @(posedge ref_clk);
        do_reset(2);
        run(2, 2'h0, 1'b0, 1'b0);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
